//--- common/fsp_pkg.sv
// Constants and carrier types for the flash self-programming controller.
// Assumes one 200 MHz clock shared by the bus, the flash array and the EEPROM.
// Notes on behaviour
// - Code 01 loads data pair into buffer
// - CPU stalled during whole erase or write
// - Buffer cleared after write, clear, reset
// - EEPROM write during loading discards buffer
// - Fuse read armed: load returns fuse/lock
// - Write bit self-clears on done or timeout
// - Erase bit self-clears on done or timeout
// - Store enable arms four cycles, then clears
// - Store enable stays set while busy
// - Plain load picks byte by pointer least bit
// - Only listed command codes take effect
// - Clear bit empties the page buffer
// - Upper three control bits read zero
// - EEPROM busy blocks commands and fuse reads
// - Erase uses only the page field
// - Buffer load ignores pointer bit zero
// - Erase or write lasts 3.7 to 4.5 ms
// - Pointer 0 low fuse, 1 lock, 3 high
// - Programmed bits read zero, unprogrammed one
package fsp_pkg;
  localparam logic [7:0] ADDR_CSR    = 8'h00;
  localparam logic [7:0] ADDR_PTR    = 8'h04;
  localparam logic [7:0] ADDR_DATA   = 8'h08;
  localparam logic [7:0] ADDR_INSTR  = 8'h0C;
  localparam logic [7:0] ADDR_LOAD   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  localparam int INSTR_STORE_BIT = 0;
  localparam int INSTR_LOAD_BIT  = 1;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_EE_BIT     = 1;
  localparam int STAT_ARMED_BIT  = 2;

  localparam logic [4:0] CMD_LOAD  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_FUSE  = 5'h09;
  localparam logic [4:0] CMD_CLEAR = 5'h11;
  localparam logic [4:0] CSR_IDLE  = 5'h00;
  localparam logic [2:0] CSR_RSVD  = 3'h0;

  localparam logic [2:0] STORE_WIN = 3'h4;
  localparam logic [2:0] LOAD_WIN  = 3'h3;

  localparam int WORD_LSB  = 1;
  localparam int WORD_W    = 5;
  localparam int PAGE_LSB  = 6;
  localparam int PAGE_W    = 7;
  localparam int BUF_WORDS = 32;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  localparam logic [15:0] PTR_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] PTR_LOCK      = 16'h0001;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;

  localparam int CLK_PERIOD_NS = 5;
  localparam int OP_MIN_NS     = 3_700_000;
  localparam int OP_MAX_NS     = 4_500_000;
  localparam int OP_MIN_CYC    = (OP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OP_MAX_CYC    = OP_MAX_NS / CLK_PERIOD_NS;
  localparam int OP_CNT_W      = 20;

  typedef enum logic [1:0] {FSP_IDLE, FSP_ARMED, FSP_OP_BUSY} fsp_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } fsp_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } fsp_apb_rsp_t;

  typedef struct packed {
    logic              erase;
    logic              write;
    logic [PAGE_W-1:0] page;
  } fsp_flash_cmd_t;

  typedef struct packed {
    logic [7:0] fuse_low;
    logic [7:0] fuse_high;
    logic [7:0] lock_bits;
  } fsp_fuse_t;
endpackage : fsp_pkg

//--- verilog/fsp_op_timer.sv
// Self-timed flash operation counter: busy for a fixed number of cycles.
// Assumes start is a one-cycle pulse that never comes while busy.
`timescale 1ns/1ps
`default_nettype none
module fsp_op_timer #(
  parameter int unsigned CYCLES = fsp_pkg::OP_MIN_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  import fsp_pkg::*;

  localparam logic [OP_CNT_W-1:0] LOAD_VAL = CYCLES[OP_CNT_W-1:0];
  localparam logic [OP_CNT_W-1:0] CNT_ONE  = 20'h0_0001;

  logic [OP_CNT_W-1:0] cnt_ff;
  logic [OP_CNT_W-1:0] nxt_cnt;
  logic [OP_CNT_W-1:0] len_ff;

  assign nxt_cnt = start ? LOAD_VAL : (cnt_ff != '0) ? cnt_ff - CNT_ONE : cnt_ff;
  assign busy    = (cnt_ff != '0);
  assign done    = (cnt_ff == CNT_ONE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Helper that counts busy cycles so the length can be checked.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_ff <= '0;
    end else begin
      len_ff <= start ? CNT_ONE : busy ? len_ff + CNT_ONE : len_ff;
    end
  end

  op_length_a: assert property (@(posedge pclk) disable iff (!presetn)
    done |-> (len_ff == LOAD_VAL))
    else $error("flash operation length differs from the set count");
  start_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> busy)
    else $error("timer not busy after start");
  done_ends_a: assert property (@(posedge pclk) disable iff (!presetn)
    done |=> !busy)
    else $error("timer still busy after done");
endmodule : fsp_op_timer
`default_nettype wire

//--- verilog/fsp_flash_ctrl.sv
// Flash self-programming controller: APB registers, command arming,
// temporary page buffer, fuse/lock read-back and self-timed erase/write.
// Assumes the flash array, fuse store and EEPROM controller share pclk.
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_ctrl #(
  parameter int unsigned OP_CYCLES = fsp_pkg::OP_MIN_CYC
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire fsp_pkg::fsp_apb_req_t    apb_req,
  output fsp_pkg::fsp_apb_rsp_t         apb_rsp,
  input  wire logic                     eeprom_write_busy,
  input  wire fsp_pkg::fsp_fuse_t       fuse_in,
  input  wire logic [15:0]              flash_word,
  output logic [14:0]                   flash_word_addr,
  output fsp_pkg::fsp_flash_cmd_t       flash_cmd,
  input  wire logic [fsp_pkg::WORD_W-1:0] flash_buf_idx,
  output logic [15:0]                   flash_buf_word,
  output logic                          flash_busy,
  output logic                          cpu_halt
);
  import fsp_pkg::*;

  fsp_state_t          state_ff;
  fsp_state_t          nxt_state;
  logic [4:0]          csr_ff;
  logic [4:0]          nxt_csr;
  logic [2:0]          win_ff;
  logic [2:0]          nxt_win;
  logic [15:0]         ptr_ff;
  logic [15:0]         data_ff;
  logic [7:0]          load_ff;
  logic [7:0]          nxt_load;
  logic [31:0]         prdata_ff;
  logic                slverr_ff;
  logic                ee_prev_ff;
  fsp_flash_cmd_t      cmd_ff;
  logic [15:0]         buf_word_ff;
  logic [BUF_WORDS-1:0] valid_ff;
  logic [15:0]         mem [BUF_WORDS];

  logic                op_busy;
  logic                op_done;
  logic                op_start;

  // Bus phase decode.
  wire        setup    = apb_req.psel & ~apb_req.penable;
  wire        access   = apb_req.psel & apb_req.penable & apb_rsp.pready;
  wire [7:0]  addr     = apb_req.paddr;
  wire        hit_csr  = (addr == ADDR_CSR);
  wire        hit_ptr  = (addr == ADDR_PTR);
  wire        hit_data = (addr == ADDR_DATA);
  wire        hit_ins  = (addr == ADDR_INSTR);
  wire        hit_load = (addr == ADDR_LOAD);
  wire        hit_stat = (addr == ADDR_STATUS);
  wire        mapped   = hit_csr | hit_ptr | hit_data | hit_ins | hit_load | hit_stat;
  wire        wr       = access & apb_req.pwrite;
  wire        wr_csr   = wr & hit_csr;
  wire        wr_ins   = wr & hit_ins;
  wire [4:0]  cmd      = apb_req.pwdata[4:0];

  wire cmd_known = (cmd == CMD_LOAD) | (cmd == CMD_ERASE) | (cmd == CMD_WRITE)
                 | (cmd == CMD_FUSE) | (cmd == CMD_CLEAR);
  wire arm     = wr_csr & cmd_known & ~eeprom_write_busy & (state_ff != FSP_OP_BUSY);
  wire armed   = (state_ff == FSP_ARMED) & (win_ff != 3'h0);
  wire store   = wr_ins & apb_req.pwdata[INSTR_STORE_BIT] & armed & ~eeprom_write_busy;
  wire loadi   = wr_ins & apb_req.pwdata[INSTR_LOAD_BIT];
  wire fuse_ok = armed & (csr_ff == CMD_FUSE) & (win_ff > (STORE_WIN - LOAD_WIN))
               & ~eeprom_write_busy;
  wire expire  = (state_ff == FSP_ARMED) & (win_ff == 3'h1) & ~store & ~(loadi & fuse_ok);

  wire [WORD_W-1:0] word_idx = ptr_ff[WORD_LSB +: WORD_W];
  wire [PAGE_W-1:0] page_idx = ptr_ff[PAGE_LSB +: PAGE_W];
  wire do_load   = store & (csr_ff == CMD_LOAD);
  wire do_erase  = store & (csr_ff == CMD_ERASE);
  wire do_write  = store & (csr_ff == CMD_WRITE);
  assign op_start = do_erase | do_write;

  wire write_done = op_done & (csr_ff == CMD_WRITE);
  wire clr_cmd    = arm & (cmd == CMD_CLEAR);
  wire ee_rise    = eeprom_write_busy & ~ee_prev_ff & (valid_ff != '0);
  wire buf_clear  = write_done | clr_cmd | ee_rise;

  wire [7:0] fuse_byte = (ptr_ff == PTR_LOCK)      ? fuse_in.lock_bits :
                         (ptr_ff == PTR_FUSE_HIGH) ? fuse_in.fuse_high :
                         (ptr_ff == PTR_FUSE_LOW)  ? fuse_in.fuse_low  :
                         ptr_ff[0] ? fuse_in.lock_bits : fuse_in.fuse_low;
  wire [7:0] flash_byte = ptr_ff[0] ? flash_word[15:8] : flash_word[7:0];

  wire [7:0]  csr_rd  = {CSR_RSVD, csr_ff};
  wire [31:0] stat_rd = {29'h0, (state_ff == FSP_ARMED), eeprom_write_busy, op_busy};
  wire [31:0] rd_mux  = hit_csr  ? {24'h0, csr_rd} :
                        hit_ptr  ? {16'h0, ptr_ff} :
                        hit_data ? {16'h0, data_ff} :
                        hit_load ? {24'h0, load_ff} :
                        hit_stat ? stat_rd : 32'h0;

  fsp_op_timer #(
    .CYCLES (OP_CYCLES)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (op_start),
    .busy    (op_busy),
    .done    (op_done)
  );

  // Sequencer next state.
  always_comb begin
    nxt_state = state_ff;
    nxt_csr   = csr_ff;
    nxt_win   = win_ff;
    case (state_ff)
      FSP_IDLE: begin
        if (arm) begin
          nxt_state = FSP_ARMED;
          nxt_csr   = cmd;
          nxt_win   = STORE_WIN;
        end
      end
      FSP_ARMED: begin
        nxt_win = win_ff - 3'h1;
        if (op_start) begin
          nxt_state = FSP_OP_BUSY;
        end else if (store | (loadi & fuse_ok)) begin
          nxt_state = FSP_IDLE;
          nxt_csr   = CSR_IDLE;
          nxt_win   = 3'h0;
        end else if (arm) begin
          nxt_csr = cmd;
          nxt_win = STORE_WIN;
        end else if (expire) begin
          nxt_state = FSP_IDLE;
          nxt_csr   = CSR_IDLE;
        end
      end
      FSP_OP_BUSY: begin
        nxt_win = 3'h0;
        if (op_done) begin
          nxt_state = FSP_IDLE;
          nxt_csr   = CSR_IDLE;
        end
      end
      default: begin
        nxt_state = FSP_IDLE;
        nxt_csr   = CSR_IDLE;
        nxt_win   = 3'h0;
      end
    endcase
  end

  always_comb begin
    nxt_load = load_ff;
    if (loadi && fuse_ok) begin
      nxt_load = fuse_byte;
    end else if (loadi) begin
      nxt_load = flash_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= FSP_IDLE;
      csr_ff   <= CSR_IDLE;
      win_ff   <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      csr_ff   <= nxt_csr;
      win_ff   <= nxt_win;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_ff  <= 16'h0000;
      data_ff <= 16'h0000;
      load_ff <= 8'h00;
    end else begin
      ptr_ff  <= (wr & hit_ptr) ? apb_req.pwdata[15:0] : ptr_ff;
      data_ff <= (wr & hit_data) ? apb_req.pwdata[15:0] : data_ff;
      load_ff <= nxt_load;
    end
  end

  // Read data is captured in the setup cycle so it leaves a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
      slverr_ff <= ~mapped;
    end
  end

  assign apb_rsp.pready  = ~op_busy;
  assign apb_rsp.prdata  = prdata_ff;
  assign apb_rsp.pslverr = slverr_ff;
  assign cpu_halt        = op_busy;
  assign flash_busy      = op_busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff     <= '0;
      ee_prev_ff <= 1'b0;
    end else begin
      cmd_ff.erase <= do_erase;
      cmd_ff.write <= do_write;
      cmd_ff.page  <= op_start ? page_idx : cmd_ff.page;
      ee_prev_ff   <= eeprom_write_busy;
    end
  end

  assign flash_cmd       = cmd_ff;
  assign flash_word_addr = ptr_ff[15:1];

  always_ff @(posedge pclk) begin
    if (do_load) begin
      mem[word_idx] <= data_ff;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < BUF_WORDS; gi++) begin : g_valid
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          valid_ff[gi] <= 1'b0;
        end else if (buf_clear) begin
          valid_ff[gi] <= 1'b0;
        end else if (do_load && (word_idx == gi)) begin
          valid_ff[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // A cleared slot reads as erased flash so an unloaded word programs nothing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_word_ff <= ERASED_WORD;
    end else begin
      buf_word_ff <= valid_ff[flash_buf_idx] ? mem[flash_buf_idx] : ERASED_WORD;
    end
  end

  assign flash_buf_word = buf_word_ff;

  // Checks beside the logic.
  halt_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    op_start |=> (cpu_halt && !apb_rsp.pready))
    else $error("cpu not halted after flash start");
  enable_held_a: assert property (@(posedge pclk) disable iff (!presetn)
    op_busy |-> csr_ff[0])
    else $error("store enable dropped while busy");
  bits_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    op_done |=> (csr_ff == CSR_IDLE))
    else $error("command bits not cleared after operation");
  arm_expire_a: assert property (@(posedge pclk) disable iff (!presetn)
    (arm && state_ff == FSP_IDLE) ##1 (!wr_ins && !arm) [*4] |=> (csr_ff == CSR_IDLE))
    else $error("armed command did not expire after four cycles");
  bad_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_csr && !cmd_known && state_ff == FSP_IDLE) |=> (csr_ff == CSR_IDLE))
    else $error("unknown command code took effect");
  ee_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_csr && eeprom_write_busy && state_ff == FSP_IDLE) |=> (state_ff == FSP_IDLE))
    else $error("command accepted while EEPROM busy");
  buf_wipe_a: assert property (@(posedge pclk) disable iff (!presetn)
    buf_clear |=> (valid_ff == '0))
    else $error("page buffer not cleared");
  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !apb_req.pwrite && hit_csr) |=> (prdata_ff[7:5] == CSR_RSVD))
    else $error("reserved control bits read non-zero");
  fuse_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (loadi && fuse_ok && ptr_ff == PTR_LOCK) |=> (load_ff == $past(fuse_in.lock_bits)))
    else $error("lock byte not returned by armed load");
endmodule : fsp_flash_ctrl
`default_nettype wire

//--- test/fsp_flash_model.sv
// Far-side model: flash array, fuse store and a page walker for page writes.
// Assumes buffer words appear one cycle after the index and only pages 0..3 are used.
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model #(
  parameter logic [7:0] FUSE_LOW  = 8'h6A,
  parameter logic [7:0] FUSE_HIGH = 8'hDC,
  parameter logic [7:0] LOCK_BITS = 8'hFE
) (
  input  wire logic                    pclk,
  input  wire fsp_pkg::fsp_flash_cmd_t flash_cmd,
  input  wire logic [14:0]             flash_word_addr,
  input  wire logic [15:0]             flash_buf_word,
  output logic [15:0]                  flash_word,
  output logic [fsp_pkg::WORD_W-1:0]   flash_buf_idx,
  output fsp_pkg::fsp_fuse_t           fuse_in
);
  import fsp_pkg::*;
  logic [15:0]       mem [0:127];
  logic [PAGE_W-1:0] page_ff;
  logic [5:0]        walk_ff;
  logic [4:0]        last_ff;

  assign fuse_in    = '{fuse_low: FUSE_LOW, fuse_high: FUSE_HIGH, lock_bits: LOCK_BITS};
  assign flash_word = mem[flash_word_addr[6:0]];

  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = ERASED_WORD;
    end
    walk_ff = '0;
    last_ff = '0;
    page_ff = '0;
    flash_buf_idx = '0;
  end

  // The walk needs 33 cycles, so the operation time must be longer than that.
  always @(posedge pclk) begin
    if (flash_cmd.erase) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        mem[{flash_cmd.page[1:0], i[4:0]}] <= ERASED_WORD;
      end
    end
    if (flash_cmd.write) begin
      page_ff       <= flash_cmd.page;
      walk_ff       <= 6'd33;
      flash_buf_idx <= '0;
    end else if (walk_ff != 6'd0) begin
      walk_ff       <= walk_ff - 6'd1;
      last_ff       <= flash_buf_idx;
      flash_buf_idx <= flash_buf_idx + 5'd1;
      if (walk_ff <= 6'd32) begin
        mem[{page_ff[1:0], last_ff}] <= flash_buf_word;
      end
    end
  end
endmodule // fsp_flash_model
`default_nettype wire

//--- test/test_flash_self_program_control.sv
// Self-checking bench: APB tasks drive the controller, a flash model sits behind it.
// Assumes OP_CYCLES is cut to 40 so that a page walk ends inside an operation.
`timescale 1ns/1ps
`default_nettype none
module test_flash_self_program_control;
  import fsp_pkg::*;
  localparam logic [7:0]  FL = 8'h6A;
  localparam logic [7:0]  FH = 8'hDC;
  localparam logic [7:0]  LK = 8'hFE;
  localparam logic [15:0] PG = 16'h0040;
  logic              pclk;
  logic              presetn;
  logic              ee_busy;
  fsp_apb_req_t      req;
  fsp_apb_rsp_t      rsp;
  fsp_fuse_t         fuse;
  fsp_flash_cmd_t    fcmd;
  logic [15:0]       fword;
  logic [14:0]       faddr;
  logic [WORD_W-1:0] fidx;
  logic [15:0]       fbuf;
  logic              halt;
  logic              fbusy;
  logic [31:0]       rd;
  logic              err;
  int                mismatches;
  int                compares;

  fsp_flash_ctrl #(.OP_CYCLES(40)) dut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .eeprom_write_busy(ee_busy), .fuse_in(fuse), .flash_word(fword),
    .flash_word_addr(faddr), .flash_cmd(fcmd), .flash_buf_idx(fidx),
    .flash_buf_word(fbuf), .flash_busy(fbusy), .cpu_halt(halt)
  );

  fsp_flash_model #(.FUSE_LOW(FL), .FUSE_HIGH(FH), .LOCK_BITS(LK)) flash (
    .pclk(pclk), .flash_cmd(fcmd), .flash_word_addr(faddr),
    .flash_buf_word(fbuf), .flash_word(fword), .flash_buf_idx(fidx), .fuse_in(fuse)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // An idle cycle leads each transfer, so no signal is assigned twice in one step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1 && n < 2000) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 2000) begin
      mismatches++;
      close_out();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask

  task automatic cmd(input logic [15:0] p, input logic [15:0] d, input logic [4:0] c);
    apb(1'b1, ADDR_PTR, {16'h0000, p});
    apb(1'b1, ADDR_DATA, {16'h0000, d});
    apb(1'b1, ADDR_CSR, {27'h0, c});
    apb(1'b1, ADDR_INSTR, 32'h0000_0001);
  endtask

  task automatic rdf(input logic [15:0] p, input logic [7:0] exp);
    apb(1'b1, ADDR_PTR, {16'h0000, p});
    apb(1'b1, ADDR_INSTR, 32'h0000_0002);
    rdc(ADDR_LOAD, {24'h0, exp}, "flash byte");
  endtask

  logic [4:0]  bad [6]  = '{5'h07, 5'h0B, 5'h13, 5'h1F, 5'h02, 5'h08};
  logic [15:0] fptr [3] = '{16'h0000, 16'h0001, 16'h0003};
  logic [7:0]  fexp [3] = '{FL, LK, FH};

  initial begin
    req = '0;
    ee_busy = 1'b0;
    presetn = 1'b0;
    mismatches = 0;
    compares = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_CSR, 32'h0000_0000, "csr reset");
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped error", {31'h0, err}, 32'h0000_0001);
    apb(1'b1, ADDR_CSR, 32'h0000_00E0);
    rdc(ADDR_CSR, 32'h0000_0000, "csr reserved");
    foreach (bad[i]) begin
      apb(1'b1, ADDR_CSR, {27'h0, bad[i]});
      rdc(ADDR_CSR, 32'h0000_0000, "csr bad code");
    end
    $display("test reset_and_codes finished");
    foreach (fptr[i]) begin
      apb(1'b1, ADDR_PTR, {16'h0000, fptr[i]});
      apb(1'b1, ADDR_CSR, {27'h0, CMD_FUSE});
      apb(1'b1, ADDR_INSTR, 32'h0000_0002);
      rdc(ADDR_LOAD, {24'h0, fexp[i]}, "fuse byte");
      rdc(ADDR_CSR, 32'h0000_0000, "csr after fuse");
    end
    $display("test fuse_read finished");
    cmd(PG | 16'h0001, 16'h1234, CMD_LOAD);
    cmd(PG | 16'h000A, 16'hABCD, CMD_LOAD);
    rdc(ADDR_CSR, 32'h0000_0000, "csr after load");
    apb(1'b1, ADDR_PTR, {16'h0000, PG | 16'h0002});
    apb(1'b1, ADDR_DATA, 32'h0000_2222);
    apb(1'b1, ADDR_CSR, {27'h0, CMD_LOAD});
    rdc(ADDR_STATUS, 32'h0000_0004, "status armed");
    repeat (5) @(posedge pclk);
    rdc(ADDR_CSR, 32'h0000_0000, "csr expired");
    apb(1'b1, ADDR_INSTR, 32'h0000_0001);
    cmd(PG | 16'h003F, 16'h0F0F, CMD_ERASE);
    repeat (2) @(posedge pclk);
    chk("halt in erase", {31'h0, halt}, 32'h0000_0001);
    chk("busy in erase", {31'h0, fbusy}, 32'h0000_0001);
    rdc(ADDR_CSR, 32'h0000_0003, "csr erase busy");
    rdc(ADDR_CSR, 32'h0000_0000, "csr erase done");
    chk("halt after erase", {31'h0, halt}, 32'h0000_0000);
    cmd(PG, 16'h0000, CMD_WRITE);
    repeat (2) @(posedge pclk);
    chk("halt in write", {31'h0, halt}, 32'h0000_0001);
    rdc(ADDR_CSR, 32'h0000_0005, "csr write busy");
    rdc(ADDR_CSR, 32'h0000_0000, "csr write done");
    rdf(PG, 8'h34);
    rdf(PG | 16'h0001, 8'h12);
    rdf(PG | 16'h000B, 8'hAB);
    rdf(PG | 16'h0002, 8'hFF);
    $display("test program_page finished");
    cmd(PG | 16'h0004, 16'h5555, CMD_LOAD);
    cmd(PG, 16'h0000, CMD_CLEAR);
    cmd(PG | 16'h0006, 16'h1111, CMD_LOAD);
    ee_busy <= 1'b1;
    apb(1'b1, ADDR_CSR, {27'h0, CMD_FUSE});
    rdc(ADDR_CSR, 32'h0000_0000, "csr eeprom busy");
    rdc(ADDR_STATUS, 32'h0000_0002, "status eeprom busy");
    ee_busy <= 1'b0;
    cmd(PG, 16'h0000, CMD_WRITE);
    // The read set up while busy captures the busy control value.
    rdc(ADDR_CSR, 32'h0000_0005, "csr write busy");
    rdc(ADDR_CSR, 32'h0000_0000, "csr write done");
    rdf(PG | 16'h0004, 8'hFF);
    rdf(PG | 16'h0006, 8'hFF);
    rdf(PG, 8'hFF);
    $display("test buffer_clears finished");
    cmd(PG | 16'h0008, 16'h7777, CMD_LOAD);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_CSR, 32'h0000_0000, "csr after reset");
    cmd(PG, 16'h0000, CMD_WRITE);
    rdc(ADDR_CSR, 32'h0000_0005, "csr reset write busy");
    rdc(ADDR_CSR, 32'h0000_0000, "csr reset write done");
    rdf(PG | 16'h0008, 8'hFF);
    $display("test reset_clears finished");
    close_out();
  end
endmodule // test_flash_self_program_control
`default_nettype wire
